// ---- hw/lbs_map.vh ----
// constants and field positions for the local-bus support pin logic
`ifndef LBS_MAP_VH
`define LBS_MAP_VH
`define LBS_IRQ_A_POL_BIT  1
`define LBS_IRQ_B_POL_BIT  4
`define LBS_PIN0_SEL_HI    1
`define LBS_PIN0_SEL_LO    0
`define LBS_PIN1_SEL_HI    4
`define LBS_PIN1_SEL_LO    3
`define LBS_PIN2_SEL_HI    7
`define LBS_PIN2_SEL_LO    6
`define LBS_PIN3_SEL_HI    10
`define LBS_PIN3_SEL_LO    9
`define LBS_CTRL_WIDTH     11
`define LBS_CTRL_RESET     11'h000
`define LBS_SEL_USER       2'h0
`define LBS_LOCK_TAIL      1
`endif

// ---- hw/lbs_cs_window.v ----
// address window compare for one chip select
`timescale 1ns/1ps
`default_nettype none
module lbs_cs_window #(
    parameter AW = 28
) (
    input  wire          sys_clk,
    input  wire          rst,
    input  wire [AW-1:0] access_addr,
    input  wire          access_active,
    input  wire [AW-1:0] win_base,
    input  wire [AW-1:0] win_mask,
    output reg           hit
);
    // registered compare; mask bits set mean "ignored" inside the window
    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            hit <= 1'b0;
        else
            hit <= access_active &&
                   (((access_addr ^ win_base) & ~win_mask) == {AW{1'b0}});
    end
endmodule
`default_nettype wire

// ---- hw/lbs_support.v ----
// local-bus support pins: hold handoff, local irqs, reset, strap, gp pins
`timescale 1ns/1ps
`default_nettype none
`include "lbs_map.vh"
module lbs_support #(
    parameter AW = 28
) (
    input  wire                       sys_clk,
    input  wire                       rst,
    input  wire                       bus_hold_request,
    input  wire                       device_needs_bus,
    output reg                        bus_grant_ack,
    input  wire                       local_irq_in_a,
    input  wire                       local_irq_in_b,
    input  wire [6:0]                 irq_control_status_reg,
    output reg                        host_irq,
    output wire                       local_reset_out_n,
    input  wire                       mode_strap,
    output reg                        mux_mode,
    input  wire [`LBS_CTRL_WIDTH-1:0] eeprom_ctrl,
    input  wire                       eeprom_load,
    input  wire [`LBS_CTRL_WIDTH-1:0] sw_ctrl,
    input  wire                       sw_ctrl_write,
    input  wire [3:0]                 user_dir,
    input  wire [3:0]                 user_out,
    output reg  [3:0]                 user_in,
    input  wire                       wait_active,
    input  wire                       atomic_addr_cycle,
    input  wire                       access_done,
    input  wire                       host_frame_n,
    input  wire                       host_lock_n,
    input  wire [AW-1:0]              access_addr,
    input  wire                       access_active,
    input  wire [AW-1:0]              cs_c_base,
    input  wire [AW-1:0]              cs_c_mask,
    input  wire [AW-1:0]              cs_d_base,
    input  wire [AW-1:0]              cs_d_mask,
    input  wire [3:0]                 gp_pin_in,
    output reg  [3:0]                 gp_pin_out,
    output reg  [3:0]                 gp_pin_oe
);
    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers: first stage read only by second stage
    reg [5:0] sync1;
    reg [5:0] sync2;
    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            // hold request resets to "no request" so no false grant follows reset
            sync1 <= 6'h3e;
            sync2 <= 6'h3e;
        end
        else
        begin
            sync1 <= {mode_strap, host_lock_n, host_frame_n,
                      local_irq_in_b, local_irq_in_a, bus_hold_request};
            sync2 <= sync1;
        end
    end
    wire hold_req_s = sync2[0];
    wire irq_a_s    = sync2[1];
    wire irq_b_s    = sync2[2];
    wire frame_n_s  = sync2[3];
    wire lock_n_s   = sync2[4];
    wire mode_s     = sync2[5];

    reg [3:0] gp_sync1;
    reg [3:0] gp_sync2;
    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            gp_sync1 <= 4'h0;
            gp_sync2 <= 4'h0;
        end
        else
        begin
            gp_sync1 <= gp_pin_in;
            gp_sync2 <= gp_sync1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // local reset follows device reset directly, no clock needed
    assign local_reset_out_n = ~rst;

    // strap is caught after release, once the synchroniser holds the real pin
    // level and no longer its reset value
    reg       strap_taken;
    reg [1:0] strap_wait;
    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            strap_taken <= 1'b0;
            strap_wait  <= 2'h0;
            mux_mode    <= 1'b0;
        end
        else if (strap_wait != 2'h2)
            strap_wait <= strap_wait + 2'h1;
        else if (!strap_taken)
        begin
            strap_taken <= 1'b1;
            mux_mode    <= mode_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // hold handoff: grant only while requested and device does not need bus
    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            bus_grant_ack <= 1'b0;
        else if (!hold_req_s)
            bus_grant_ack <= 1'b0;
        else if (device_needs_bus)
            bus_grant_ack <= 1'b0;
        else
            bus_grant_ack <= 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    // local irqs: polarity bit set means active high, level passes through
    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            host_irq <= 1'b0;
        else
            host_irq <= (irq_a_s == irq_control_status_reg[`LBS_IRQ_A_POL_BIT]) ||
                        (irq_b_s == irq_control_status_reg[`LBS_IRQ_B_POL_BIT]);
    end

    ////////////////////////////////////////////////////////////////////////
    // pin function control; a software write in the same cycle as a load wins
    reg [`LBS_CTRL_WIDTH-1:0] misc_control_reg;
    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            misc_control_reg <= `LBS_CTRL_RESET;
        else if (sw_ctrl_write)
            misc_control_reg <= sw_ctrl;
        else if (eeprom_load)
            misc_control_reg <= eeprom_ctrl;
    end

    // any non-zero select code picks the special function
    function is_special;
        input [1:0] sel;
        begin
            is_special = (sel != `LBS_SEL_USER);
        end
    endfunction

    wire [3:0] special;
    assign special[0] = is_special(misc_control_reg[`LBS_PIN0_SEL_HI:`LBS_PIN0_SEL_LO]);
    assign special[1] = is_special(misc_control_reg[`LBS_PIN1_SEL_HI:`LBS_PIN1_SEL_LO]);
    assign special[2] = is_special(misc_control_reg[`LBS_PIN2_SEL_HI:`LBS_PIN2_SEL_LO]);
    assign special[3] = is_special(misc_control_reg[`LBS_PIN3_SEL_HI:`LBS_PIN3_SEL_LO]);

    ////////////////////////////////////////////////////////////////////////
    // atomic lock: one-hot idle / locked / tail states
    localparam [2:0] LK_IDLE = 3'h1;
    localparam [2:0] LK_HELD = 3'h2;
    localparam [2:0] LK_TAIL = 3'h4;
    reg [2:0] lock_state;
    reg [2:0] next_lock_state;
    // tail keeps lock one clock past the unlock cycle (frame low, lock high) before release
    reg       tail_seen;
    reg       next_tail_seen;
    wire      unlock_seen = !frame_n_s && lock_n_s;
    always @*
    begin
        next_lock_state = lock_state;
        next_tail_seen  = tail_seen;
        case (lock_state)
            LK_IDLE:
            begin
                next_tail_seen = 1'b0;
                if (atomic_addr_cycle)
                    next_lock_state = LK_HELD;
            end
            LK_HELD:
            begin
                if (access_done)
                    next_tail_seen = 1'b1;
                if (unlock_seen)
                    next_lock_state = LK_TAIL;
            end
            LK_TAIL:
            begin
                next_tail_seen  = 1'b0;
                next_lock_state = LK_IDLE;
            end
            default:
                next_lock_state = LK_IDLE;
        endcase
    end
    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            lock_state <= LK_IDLE;
            tail_seen  <= 1'b0;
        end
        else
        begin
            lock_state <= next_lock_state;
            tail_seen  <= next_tail_seen;
        end
    end
    // lock is low from the address cycle through the tail clock
    wire atomic_lock_out_n = (lock_state == LK_IDLE) && !atomic_addr_cycle;

    ////////////////////////////////////////////////////////////////////////
    // chip select windows
    wire cs_c_hit;
    wire cs_d_hit;
    lbs_cs_window #(.AW(AW)) u_cs_c (
        .sys_clk       (sys_clk),
        .rst           (rst),
        .access_addr   (access_addr),
        .access_active (access_active),
        .win_base      (cs_c_base),
        .win_mask      (cs_c_mask),
        .hit           (cs_c_hit)
    );
    lbs_cs_window #(.AW(AW)) u_cs_d (
        .sys_clk       (sys_clk),
        .rst           (rst),
        .access_addr   (access_addr),
        .access_active (access_active),
        .win_base      (cs_d_base),
        .win_mask      (cs_d_mask),
        .hit           (cs_d_hit)
    );
    wire stall_indicator_n = !wait_active;
    wire chip_select_c_n   = !cs_c_hit;
    wire chip_select_d_n   = !cs_d_hit;

    ////////////////////////////////////////////////////////////////////////
    // pin drivers; special functions always drive, user io follows direction
    wire [3:0] func_val = {chip_select_d_n, chip_select_c_n,
                           atomic_lock_out_n, stall_indicator_n};
    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            gp_pin_out <= 4'h0;
            gp_pin_oe  <= 4'h0;
            user_in    <= 4'h0;
        end
        else
        begin
            gp_pin_out <= (special & func_val) | (~special & user_out);
            gp_pin_oe  <= special | user_dir;
            user_in    <= gp_sync2;
        end
    end
endmodule
`default_nettype wire

// ---- sim/lbs_support_asserts.sv ----
// concurrent checks on the ports of the local-bus support block
`timescale 1ns/1ps
`default_nettype none
module lbs_support_asserts #(
    parameter AW = 28
) (
    input wire logic          sys_clk,
    input wire logic          rst,
    input wire logic          bus_hold_request,
    input wire logic          device_needs_bus,
    input wire logic          bus_grant_ack,
    input wire logic          local_irq_in_a,
    input wire logic          local_irq_in_b,
    input wire logic [6:0]    irq_control_status_reg,
    input wire logic          host_irq,
    input wire logic          local_reset_out_n,
    input wire logic [10:0]   eeprom_ctrl,
    input wire logic          eeprom_load,
    input wire logic [10:0]   sw_ctrl,
    input wire logic          sw_ctrl_write,
    input wire logic          atomic_addr_cycle,
    input wire logic          host_frame_n,
    input wire logic          host_lock_n,
    input wire logic [AW-1:0] access_addr,
    input wire logic          access_active,
    input wire logic [AW-1:0] cs_c_base,
    input wire logic [AW-1:0] cs_c_mask,
    input wire logic [3:0]    gp_pin_out,
    input wire logic [3:0]    gp_pin_oe
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    logic [10:0] cfg;
    logic [1:0]  quiet;
    ////////////////////////////////////////////////////////////////////////////////
    // shadow of the pin config; checks wait until a load has settled
    always @(posedge sys_clk or posedge rst)
        if (rst)
        begin
            cfg   <= 11'h000;
            quiet <= 2'h0;
        end
        else if (sw_ctrl_write || eeprom_load)
        begin
            cfg   <= sw_ctrl_write ? sw_ctrl : eeprom_ctrl;
            quiet <= 2'h0;
        end
        else if (quiet != 2'h3)
            quiet <= quiet + 2'h1;
    ////////////////////////////////////////////////////////////////////////////////
    property p_reset_out; local_reset_out_n; endproperty
    a_reset_out: assert property (p_reset_out) else $error("local reset low");
    property p_grant_rise;
        $rose(bus_grant_ack) |-> $past(bus_hold_request, 3) && !$past(device_needs_bus);
    endproperty
    a_grant_rise: assert property (p_grant_rise) else $error("grant without request");
    property p_preempt; device_needs_bus |=> !bus_grant_ack; endproperty
    a_preempt: assert property (p_preempt) else $error("grant kept on preempt");
    property p_grant_drop; !bus_hold_request [*4] |-> !bus_grant_ack; endproperty
    a_grant_drop: assert property (p_grant_drop) else $error("grant kept");
    property p_irq;
        (local_irq_in_a == irq_control_status_reg[1] ||
         local_irq_in_b == irq_control_status_reg[4]) [*4] |-> host_irq;
    endproperty
    a_irq: assert property (p_irq) else $error("host irq missing");
    property p_lock_set;
        quiet == 2'h3 && cfg[4:3] != 2'h0 && atomic_addr_cycle |=> !gp_pin_out[1] && gp_pin_oe[1];
    endproperty
    a_lock_set: assert property (p_lock_set) else $error("lock not set");
    property p_lock_rel;
        quiet == 2'h3 && cfg[4:3] != 2'h0 && !gp_pin_out[1] && !host_frame_n && host_lock_n
            && !atomic_addr_cycle |-> ##[1:6] gp_pin_out[1];
    endproperty
    a_lock_rel: assert property (p_lock_rel) else $error("lock not released");
    property p_cs_c;
        quiet == 2'h3 && cfg[7:6] != 2'h0 && access_active
            && ~|((access_addr ^ cs_c_base) & ~cs_c_mask) |-> ##2 !gp_pin_out[2];
    endproperty
    a_cs_c: assert property (p_cs_c) else $error("select c missing");
    c_grant: cover property ($rose(bus_grant_ack));
    c_irq: cover property ($rose(host_irq));
    c_lock: cover property ($fell(gp_pin_out[1]));
endmodule
bind lbs_support lbs_support_asserts #(.AW(AW)) u_chk (.*);
`default_nettype wire

// ---- sim/lbs_master_model.sv ----
// local bus master that asks for the bus and yields on preemption
`timescale 1ns/1ps
`default_nettype none
module lbs_master_model (
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic want_bus,
    input  wire logic bus_grant_ack,
    output var  logic bus_hold_request
);
    logic owned;
    logic yielded;
    // once preempted it stays off until the user drops its wish, so no re-grab
    always @(posedge sys_clk or posedge rst)
        if (rst)
        begin
            owned            <= 1'b0;
            yielded          <= 1'b0;
            bus_hold_request <= 1'b0;
        end
        else
        begin
            owned            <= want_bus && (owned || bus_grant_ack);
            yielded          <= want_bus && (yielded || (owned && !bus_grant_ack));
            bus_hold_request <= want_bus && !yielded && !(owned && !bus_grant_ack);
        end
endmodule
`default_nettype wire

// ---- sim/test_lbs_support.sv ----
// self-checking bench for the local-bus support pins
`timescale 1ns/1ps
`default_nettype none
module test_lbs_support;
    logic sys_clk = 0, rst = 1, want_bus = 0, device_needs_bus = 0, bus_hold_request;
    logic bus_grant_ack, local_irq_in_a = 1, local_irq_in_b = 1, host_irq;
    logic [6:0] irq_control_status_reg = 7'h7f;
    logic local_reset_out_n, mode_strap = 1, mux_mode, eeprom_load = 0, sw_ctrl_write = 0;
    logic [10:0] eeprom_ctrl = 11'h000, sw_ctrl = 11'h000;
    logic [3:0] user_dir = 4'h0, user_out = 4'h0, user_in, pin_drive = 4'h0;
    logic [3:0] gp_pin_in, gp_pin_out, gp_pin_oe;
    logic wait_active = 0, atomic_addr_cycle = 0, access_done = 0, access_active = 0;
    logic host_frame_n = 1, host_lock_n = 1;
    logic [27:0] access_addr = 28'h0001234, cs_c_base = 28'h0001000, cs_d_base = 28'h0002000;
    logic [27:0] cs_c_mask = 28'h0000fff, cs_d_mask = 28'h0000fff;
    int fails = 0, check_count = 0, cycles = 0;
    // wire level: the device wins where it drives, else the far side
    assign gp_pin_in = (gp_pin_oe & gp_pin_out) | (~gp_pin_oe & pin_drive);
    lbs_support dut (.*);
    lbs_master_model master (.*);
    always #12.5 sys_clk = ~sys_clk;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [3:0] exp, input logic [3:0] got);
        check_count++;
        if (got !== exp)
        begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task give_verdict;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // hang guard, well above the 113 cycles the run needs
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            fails++;
            give_verdict;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        cyc(10);
        chk(4'h0, local_reset_out_n);
        chk(4'h0, gp_pin_oe);
        rst = 0;
        cyc(4);
        chk(4'h1, mux_mode);
        want_bus = 1;
        cyc(5);
        chk(4'h1, bus_grant_ack);
        device_needs_bus = 1;
        cyc(2);
        chk(4'h0, bus_grant_ack);
        device_needs_bus = 0;
        cyc(6);
        chk(4'h0, bus_grant_ack);
        want_bus = 0;
        for (int i = 0; i < 4; i++)
        begin
            irq_control_status_reg = {2'h3, i[0], 2'h3, i[0], 1'b1};
            local_irq_in_a = ~i[0];
            local_irq_in_b = ~i[0];
            cyc(5);
            chk(4'h0, host_irq);
            if (i[1]) local_irq_in_b = i[0];
            else local_irq_in_a = i[0];
            cyc(5);
            chk(4'h1, host_irq);
        end
        eeprom_ctrl = 11'h249;
        eeprom_load = 1;
        cyc(1);
        eeprom_load = 0;
        wait_active = 1;
        cyc(4);
        chk(4'h1, gp_pin_oe[0]);
        chk(4'h0, gp_pin_out[0]);
        wait_active = 0;
        atomic_addr_cycle = 1;
        cyc(1);
        atomic_addr_cycle = 0;
        chk(4'h0, gp_pin_out[1]);
        host_frame_n = 0;
        host_lock_n = 0;
        cyc(1);
        host_frame_n = 1;
        host_lock_n = 1;
        cyc(8);
        chk(4'h0, gp_pin_out[1]);
        host_frame_n = 0;
        cyc(1);
        host_frame_n = 1;
        cyc(7);
        chk(4'h1, gp_pin_out[1]);
        access_active = 1;
        cyc(3);
        chk(4'hb, gp_pin_out);
        access_addr = 28'h0002010;
        cyc(3);
        chk(4'h7, gp_pin_out);
        access_active = 0;
        user_dir = 4'hf;
        user_out = 4'ha;
        sw_ctrl_write = 1;
        eeprom_load = 1;
        cyc(1);
        sw_ctrl_write = 0;
        eeprom_load = 0;
        wait_active = 1;
        cyc(4);
        chk(4'ha, gp_pin_out);
        chk(4'hf, gp_pin_oe);
        user_dir = 4'h0;
        pin_drive = 4'h5;
        cyc(5);
        chk(4'h5, user_in);
        mode_strap = 0;
        rst = 1;
        cyc(3);
        chk(4'h0, local_reset_out_n);
        rst = 0;
        cyc(4);
        chk(4'h0, mux_mode);
        give_verdict;
    end
endmodule
`default_nettype wire
